// [include/nvmc_pkg.sv]
// Constants, types and register map of the nonvolatile access control.
// Assumes a 125 MHz system clock and an AXI4-Lite register bus.
package nvmc_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int unsigned AXI_AW     = 8;
  localparam int unsigned AXI_DW     = 32;
  localparam logic [7:0]  ADDR_CTRL  = 8'h00;
  localparam logic [7:0]  ADDR_KEY   = 8'h04;
  localparam logic [7:0]  ADDR_IRQST = 8'h08;
  localparam logic [7:0]  ADDR_IRQMK = 8'h0C;
  localparam logic [7:0]  ADDR_PTR   = 8'h10;
  localparam logic [7:0]  ADDR_INFO  = 8'h14;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_TGT   = 7;
  localparam int unsigned CTRL_CFG   = 6;
  localparam int unsigned CTRL_RSV   = 5;
  localparam int unsigned CTRL_ERASE = 4;
  localparam int unsigned CTRL_ERR   = 3;
  localparam int unsigned CTRL_WEN   = 2;
  localparam int unsigned CTRL_WR    = 1;
  localparam int unsigned CTRL_RD    = 0;
  localparam logic [7:0]  CTRL_RST   = 8'h00;

  localparam logic [7:0]  KEY_FIRST  = 8'h55;
  localparam logic [7:0]  KEY_SECOND = 8'hAA;

  // ---------------------------------------------------------------
  // Interrupt status and mask fields
  // ---------------------------------------------------------------
  localparam int unsigned IRQ_W      = 3;
  localparam int unsigned IRQ_WDONE  = 0;
  localparam int unsigned IRQ_RDONE  = 1;
  localparam int unsigned IRQ_BAD    = 2;
  localparam logic [2:0]  IRQ_RST    = 3'h0;

  // Info register: bit 0 busy, bits 2:1 unlock state
  localparam int unsigned INFO_BUSY  = 0;
  localparam int unsigned INFO_KEY   = 1;

  // ---------------------------------------------------------------
  // Table pointer and targets
  // ---------------------------------------------------------------
  localparam int unsigned PTR_W      = 22;
  localparam int unsigned ERASE_LSB  = 6;
  localparam logic [21:0] PTR_RST    = 22'h000000;
  localparam logic [1:0]  TGT_EEPROM = 2'h0;
  localparam logic [1:0]  TGT_FLASH  = 2'h1;
  localparam logic [1:0]  TGT_CONFIG = 2'h2;

  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ     = 125;
  localparam int unsigned PROG_US     = 2000;
  localparam int unsigned PROG_CYCLES = PROG_US * CLK_MHZ;

  typedef enum logic [1:0] {
    KEY_LOCKED,
    KEY_HALF,
    KEY_OPEN
  } nvmc_key_t;

endpackage

// [verilog/nvmc_prog_timer.sv]
// Programming timer: runs a fixed number of cycles per start.
// Assumes start is only pulsed while the timer is idle.
`timescale 1ns/10ps
module nvmc_prog_timer #(
  parameter int unsigned CYCLES = 250000,
  parameter int unsigned CNT_W  = $clog2(CYCLES + 1)
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);

  typedef struct packed {
    logic             busy;
    logic [CNT_W-1:0] cnt;
    logic             done;
  } nvmc_tmr_t;

  nvmc_tmr_t s;
  nvmc_tmr_t next_s;

  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    if (start_i && !s.busy) begin
      next_s.busy = 1'b1;
      next_s.cnt  = CNT_W'(CYCLES - 1);
    end else if (s.busy) begin
      if (s.cnt == '0) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.cnt = s.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign busy_o = s.busy;
  assign done_o = s.done;

endmodule

// [verilog/nvmc_access_ctrl.sv]
// Nonvolatile access control registers with AXI4-Lite slave.
// Assumes the memory array acts on the start and read pulses and
// that the processor honours the stall output.
`timescale 1ns/10ps
module nvmc_access_ctrl
  import nvmc_pkg::*;
#(
  parameter int unsigned PROG_TIME = PROG_CYCLES
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [AXI_DW-1:0] s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [AXI_AW-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [AXI_DW-1:0]      s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  output logic                   mem_start_o,
  output logic                   mem_erase_o,
  output logic [1:0]             mem_target_o,
  output logic [PTR_W-1:0]       mem_addr_o,
  output logic                   mem_read_o,
  output logic                   cpu_stall_o,
  output logic                   irq_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              aw_full;
    logic [AXI_AW-1:0] aw_addr;
    logic              w_full;
    logic [AXI_DW-1:0] w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [AXI_DW-1:0] rdata;
    logic              tgt;
    logic              cfg;
    logic              erase;
    logic              err;
    logic              wen;
    logic              wr;
    logic              rd;
    nvmc_key_t         key;
    logic [IRQ_W-1:0]  irq_st;
    logic [IRQ_W-1:0]  irq_mask;
    logic [PTR_W-1:0]  ptr;
    logic              op_erase;
    logic [1:0]        op_tgt;
    logic [PTR_W-1:0]  op_addr;
    logic              start_p;
    logic              read_p;
  } nvmc_regs_t;

  nvmc_regs_t s;
  nvmc_regs_t next_s;

  logic tmr_done;

  // ---------------------------------------------------------------
  // Programming timer
  // ---------------------------------------------------------------
  nvmc_prog_timer #(
    .CYCLES (PROG_TIME)
  ) u_timer (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .start_i   (s.start_p),
    .busy_o    (),
    .done_o    (tmr_done)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [1:0] sel_target(input logic tgt,
                                            input logic cfg);
    if (cfg) begin
      return TGT_CONFIG;
    end
    return tgt ? TGT_FLASH : TGT_EEPROM;
  endfunction

  function automatic logic [7:0] ctrl_image(input nvmc_regs_t r);
    logic [7:0] v;
    v             = CTRL_RST;
    v[CTRL_TGT]   = r.tgt;
    v[CTRL_CFG]   = r.cfg;
    v[CTRL_RSV]   = 1'b0;
    v[CTRL_ERASE] = r.erase;
    v[CTRL_ERR]   = r.err;
    v[CTRL_WEN]   = r.wen;
    v[CTRL_WR]    = r.wr;
    v[CTRL_RD]    = r.rd;
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic              aw_take;
  logic              w_take;
  logic              ar_take;
  logic              do_write;
  logic [AXI_AW-1:0] wa;
  logic [AXI_DW-1:0] wd;
  logic [3:0]        ws;
  logic [7:0]        b0;
  logic              wr_ok;

  always_comb begin
    next_s         = s;
    next_s.start_p = 1'b0;
    next_s.read_p  = 1'b0;
    aw_take  = s_axi_awvalid_i && s_axi_awready_o;
    w_take   = s_axi_wvalid_i && s_axi_wready_o;
    ar_take  = s_axi_arvalid_i && s_axi_arready_o;
    wa       = s.aw_full ? s.aw_addr : s_axi_awaddr_i;
    wd       = s.w_full ? s.w_data : s_axi_wdata_i;
    ws       = s.w_full ? s.w_strb : s_axi_wstrb_i;
    b0       = wd[7:0];
    wr_ok    = 1'b0;
    do_write = (s.aw_full || aw_take) && (s.w_full || w_take);

    // Address and data may arrive in either order
    if (aw_take) begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = s_axi_awaddr_i;
    end
    if (w_take) begin
      next_s.w_full = 1'b1;
      next_s.w_data = s_axi_wdata_i;
      next_s.w_strb = s_axi_wstrb_i;
    end
    if (s.bvalid && s_axi_bready_i) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && s_axi_rready_i) begin
      next_s.rvalid = 1'b0;
    end

    // Register write
    if (do_write) begin
      next_s.aw_full = 1'b0;
      next_s.w_full  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = RESP_OKAY;
      unique case (wa)
        ADDR_CTRL: begin
          // Fields frozen while a cycle runs
          if (ws[0] && !s.wr) begin
            next_s.tgt   = b0[CTRL_TGT];
            next_s.cfg   = b0[CTRL_CFG];
            next_s.erase = b0[CTRL_ERASE];
            next_s.err   = b0[CTRL_ERR];
            next_s.wen   = b0[CTRL_WEN];
            if (b0[CTRL_RD] && !s.rd) begin
              if (!b0[CTRL_TGT] && !b0[CTRL_CFG]) begin
                next_s.rd = 1'b1;
              end
            end
            // Zero written to the start bit has no effect
            if (b0[CTRL_WR]) begin
              wr_ok = b0[CTRL_WEN] && (s.key == KEY_OPEN);
              next_s.err = 1'b1;
              next_s.key = KEY_LOCKED;
              if (wr_ok) begin
                next_s.wr       = 1'b1;
                next_s.start_p  = 1'b1;
                next_s.op_erase = b0[CTRL_ERASE];
                next_s.op_tgt   = sel_target(b0[CTRL_TGT],
                                             b0[CTRL_CFG]);
                next_s.op_addr  = b0[CTRL_ERASE]
                  ? {s.ptr[PTR_W-1:ERASE_LSB],
                     ERASE_LSB'(0)}
                  : s.ptr;
              end else begin
                next_s.irq_st[IRQ_BAD] = 1'b1;
              end
            end
          end
        end
        ADDR_KEY: begin
          // Only walks the unlock sequence, nothing is stored
          if (ws[0]) begin
            if (b0 == KEY_FIRST) begin
              next_s.key = KEY_HALF;
            end else if (b0 == KEY_SECOND && s.key == KEY_HALF) begin
              next_s.key = KEY_OPEN;
            end else begin
              next_s.key = KEY_LOCKED;
            end
          end
        end
        ADDR_IRQST: begin
          if (ws[0]) begin
            next_s.irq_st = s.irq_st & ~wd[IRQ_W-1:0];
          end
        end
        ADDR_IRQMK: begin
          if (ws[0]) begin
            next_s.irq_mask = wd[IRQ_W-1:0];
          end
        end
        ADDR_PTR: begin
          for (int i = 0; i < PTR_W; i++) begin
            if (ws[i / 8]) begin
              next_s.ptr[i] = wd[i];
            end
          end
        end
        ADDR_INFO: begin
        end
        default: begin
          next_s.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Register read
    if (ar_take) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      next_s.rdata  = '0;
      unique case (s_axi_araddr_i)
        ADDR_CTRL: begin
          next_s.rdata[7:0] = ctrl_image(s);
        end
        ADDR_KEY: begin
          next_s.rdata = '0;
        end
        ADDR_IRQST: begin
          next_s.rdata[IRQ_W-1:0] = s.irq_st;
        end
        ADDR_IRQMK: begin
          next_s.rdata[IRQ_W-1:0] = s.irq_mask;
        end
        ADDR_PTR: begin
          next_s.rdata[PTR_W-1:0] = s.ptr;
        end
        ADDR_INFO: begin
          next_s.rdata[INFO_BUSY]          = s.wr;
          next_s.rdata[INFO_KEY +: 2]      = s.key;
        end
        default: begin
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Hardware events last, so a set beats a software clear
    if (s.rd) begin
      next_s.rd                = 1'b0;
      next_s.read_p            = 1'b1;
      next_s.irq_st[IRQ_RDONE] = 1'b1;
    end
    if (tmr_done) begin
      next_s.wr                = 1'b0;
      next_s.err               = 1'b0;
      next_s.irq_st[IRQ_WDONE] = 1'b1;
      if (s.op_erase) begin
        next_s.erase = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s          <= '0;
      s.key      <= KEY_LOCKED;
      s.wen      <= 1'b0;
      s.irq_st   <= IRQ_RST;
      s.irq_mask <= IRQ_RST;
      s.ptr      <= PTR_RST;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_awready_o = !s.aw_full && !s.bvalid;
  assign s_axi_wready_o  = !s.w_full && !s.bvalid;
  assign s_axi_bvalid_o  = s.bvalid;
  assign s_axi_bresp_o   = s.bresp;
  assign s_axi_arready_o = !s.rvalid;
  assign s_axi_rvalid_o  = s.rvalid;
  assign s_axi_rresp_o   = s.rresp;
  assign s_axi_rdata_o   = s.rdata;

  assign mem_start_o  = s.start_p;
  assign mem_erase_o  = s.op_erase;
  assign mem_target_o = s.op_tgt;
  assign mem_addr_o   = s.op_addr;
  assign mem_read_o   = s.read_p;
  assign cpu_stall_o  = s.wr;
  assign irq_o        = |(s.irq_st & s.irq_mask);

endmodule

// [test/nvmc_access_ctrl_asserts.sv]
// Checker for the access control block, bound to its top module.
// Assumes one clock domain and an active-high reset.
`timescale 1ns/10ps
module nvmc_access_ctrl_asserts
  import nvmc_pkg::*;
#(
  parameter int unsigned PROG_TIME = PROG_CYCLES
) (
  input wire logic              clk_sys_i,
  input wire logic              rst_i,
  input wire logic [AXI_AW-1:0] s_axi_araddr_i,
  input wire logic              s_axi_arvalid_i,
  input wire logic              s_axi_arready_o,
  input wire logic [AXI_DW-1:0] s_axi_rdata_o,
  input wire logic              s_axi_rvalid_o,
  input wire logic              s_axi_bvalid_o,
  input wire logic              s_axi_awready_o,
  input wire logic              s_axi_wready_o,
  input wire logic              mem_start_o,
  input wire logic              mem_erase_o,
  input wire logic [PTR_W-1:0]  mem_addr_o,
  input wire logic              mem_read_o,
  input wire logic              cpu_stall_o
);
  localparam int LIM = PROG_TIME + 4;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Length of the current stall, bounded above instead of a long range
  int stall_run;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      stall_run <= 0;
    end else if (cpu_stall_o) begin
      stall_run <= stall_run + 1;
    end else begin
      stall_run <= 0;
    end
  end
  // ---------------------------------------------------------------
  // Sequences and properties
  // ---------------------------------------------------------------
  sequence s_rd_at(logic [7:0] a);
    s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == a;
  endsequence
  sequence s_launch;
    mem_start_o ##1 cpu_stall_o;
  endsequence
  property p_key_zero;
    s_rd_at(ADDR_KEY) |=> s_axi_rvalid_o && s_axi_rdata_o == 32'h0;
  endproperty
  property p_bit5;
    s_rd_at(ADDR_CTRL) |=> s_axi_rvalid_o && !s_axi_rdata_o[5];
  endproperty
  property p_start_pulse;
    mem_start_o |=> !mem_start_o;
  endproperty
  property p_stall;
    mem_start_o |=> cpu_stall_o [*8];
  endproperty
  property p_stall_end;
    cpu_stall_o |-> stall_run <= LIM;
  endproperty
  property p_no_relaunch;
    cpu_stall_o && $past(cpu_stall_o) |-> !mem_start_o;
  endproperty
  property p_erase_addr;
    s_launch ##0 mem_erase_o |-> mem_addr_o[5:0] == 6'h0;
  endproperty
  property p_read_pulse;
    mem_read_o |=> !mem_read_o;
  endproperty
  property p_busy_ready;
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
  endproperty
  a_key_zero: assert property (p_key_zero)
    else $error("key port read not zero");
  a_bit5: assert property (p_bit5)
    else $error("control bit five read as one");
  a_start_pulse: assert property (p_start_pulse)
    else $error("start pulse longer than one cycle");
  a_stall: assert property (p_stall)
    else $error("stall missing after start");
  a_stall_end: assert property (p_stall_end)
    else $error("stall did not end in time");
  a_no_relaunch: assert property (p_no_relaunch)
    else $error("start while cycle in progress");
  a_erase_addr: assert property (p_erase_addr)
    else $error("erase address low bits not zero");
  a_read_pulse: assert property (p_read_pulse)
    else $error("read pulse longer than one cycle");
  a_busy_ready: assert property (p_busy_ready)
    else $error("ready high during write response");
endmodule
bind nvmc_access_ctrl nvmc_access_ctrl_asserts #(.PROG_TIME(PROG_TIME))
  nvmc_access_ctrl_asserts_u (.clk_sys_i, .rst_i, .s_axi_araddr_i,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o,
  .s_axi_bvalid_o, .s_axi_awready_o, .s_axi_wready_o, .mem_start_o,
  .mem_erase_o, .mem_addr_o, .mem_read_o, .cpu_stall_o);

// [test/tb.sv]
// Self-checking bench for the access control block.
// Drives the AXI4-Lite port itself; short programming time.
`timescale 1ns/10ps
module tb;
  import nvmc_pkg::*;
  localparam int unsigned PT = 20;
  logic        clk_sys_i, rst_i, s_axi_awvalid_i, s_axi_awready_o;
  logic        s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
  logic        s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
  logic        s_axi_rvalid_o, s_axi_rready_i, mem_start_o;
  logic        mem_erase_o, mem_read_o, cpu_stall_o, irq_o;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i, sel;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, seed, rd, ptr;
  logic [3:0]  s_axi_wstrb_i;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, mem_target_o, rsp;
  logic [21:0] mem_addr_o;
  int          bad_count, check_count, n_start, n_read;
  nvmc_access_ctrl #(.PROG_TIME(PT)) nvmc_access_ctrl_inst (.clk_sys_i,
    .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .mem_start_o, .mem_erase_o,
    .mem_target_o, .mem_addr_o, .mem_read_o, .cpu_stall_o, .irq_o);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // Pulses counted mid-cycle, clear of the launching edge
  always @(negedge clk_sys_i) begin
    if (mem_start_o === 1'b1) n_start++;
    if (mem_read_o === 1'b1) n_read++;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Handshakes judged at the falling edge, as the next rising edge sees
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= 1'b1;
    do begin
      @(negedge clk_sys_i);
      aw_ok = s_axi_awvalid_i && s_axi_awready_o;
      w_ok  = s_axi_wvalid_i && s_axi_wready_o;
      b_ok  = (s_axi_bvalid_o === 1'b1);
      rsp   = s_axi_bresp_o;
      @(posedge clk_sys_i);
      if (aw_ok) s_axi_awvalid_i <= 1'b0;
      if (w_ok) s_axi_wvalid_i <= 1'b0;
    end while (!b_ok);
  endtask
  task automatic rdr(input logic [7:0] a);
    logic ar_ok, r_ok;
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b1;
    do begin
      @(negedge clk_sys_i);
      ar_ok = s_axi_arvalid_i && s_axi_arready_o;
      r_ok  = (s_axi_rvalid_o === 1'b1);
      rd    = s_axi_rdata_o;
      rsp   = s_axi_rresp_o;
      @(posedge clk_sys_i);
      if (ar_ok) s_axi_arvalid_i <= 1'b0;
    end while (!r_ok);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    bad_count++;
    test_done();
  end
  initial begin
    seed = 32'h50FD9AC9;
    {bad_count, check_count, n_start, n_read} = '0;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = '0;
    {s_axi_arvalid_i, s_axi_rready_i} = '0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
    s_axi_wstrb_i = 4'hF;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    for (int i = 0; i < 4; i++) begin
      rdr(8'(4 * i));
      chk(rd, 32'h0);
    end
    wr(ADDR_KEY, xs());
    rdr(ADDR_KEY);
    chk(rd, 32'h0);
    for (int i = 0; i < 6; i++) begin
      sel = (i == 0) ? 8'hFC : 8'(xs()) & 8'hFC;
      wr(ADDR_CTRL, 32'(sel));
      rdr(ADDR_CTRL);
      chk(rd, 32'(sel & 8'hDC));
    end
    for (int i = 0; i < 2; i++) begin
      sel = i ? 8'h06 : 8'h02;
      wr(ADDR_CTRL, 32'(sel));
      rdr(ADDR_CTRL);
      chk(rd, 32'(sel & 8'hFD | 8'h08));
      rdr(ADDR_IRQST);
      chk(rd, 32'h4);
      wr(ADDR_IRQST, 32'h7);
    end
    chk(32'(n_start), 32'h0);
    for (int i = 0; i < 4; i++) begin
      sel = (i == 0) ? 8'h80 : (i == 1) ? 8'h90 : (i == 2) ? 8'h00 : 8'hC0;
      ptr = xs() & 32'h3FFFFF;
      wr(ADDR_PTR, ptr);
      wr(ADDR_KEY, 32'h55);
      wr(ADDR_KEY, 32'hAA);
      wr(ADDR_CTRL, 32'(sel | 8'h06));
      wr(ADDR_CTRL, 32'h0);
      rdr(ADDR_CTRL);
      chk(rd, 32'(sel | 8'h0E));
      chk(32'(cpu_stall_o), 32'h1);
      rdr(ADDR_INFO);
      chk(rd, 32'h1);
      while (cpu_stall_o !== 1'b0) begin
        @(posedge clk_sys_i);
      end
      @(posedge clk_sys_i);
      rdr(ADDR_CTRL);
      chk(rd, 32'(sel & 8'hEF | 8'h04));
      chk(32'(mem_target_o), i == 3 ? 32'h2 : 32'(sel[7]));
      chk(32'(mem_erase_o), 32'(sel[4]));
      chk(32'(mem_addr_o), sel[4] ? ptr & 32'h3FFFC0 : ptr);
      chk(32'(n_start), 32'(i + 1));
      rdr(ADDR_IRQST);
      chk(rd, 32'h1);
    end
    chk(32'(irq_o), 32'h0);
    wr(ADDR_IRQMK, 32'h1);
    @(posedge clk_sys_i);
    chk(32'(irq_o), 32'h1);
    wr(ADDR_IRQST, 32'h1);
    @(posedge clk_sys_i);
    chk(32'(irq_o), 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL, (i == 0) ? 32'h01 : (i == 1) ? 32'h81 : 32'h41);
      repeat (3) @(posedge clk_sys_i);
      chk(32'(n_read), 32'h1);
    end
    rdr(ADDR_IRQST);
    chk(rd, 32'h2);
    wr(8'h18, xs());
    chk(32'(rsp), 32'(RESP_SLVERR));
    rdr(8'h3C);
    chk(rd, 32'h0);
    chk(32'(rsp), 32'(RESP_SLVERR));
    test_done();
  end
endmodule
